// *** lsbx_pkg.sv ***
// Purpose: shared types and constants for the load/store/bit execution block
// Assumes: 8-bit data path, 16-bit data address space
// Notes:   operation codes are presented already decoded by the fetch stage
package lsbx_pkg;

   // cycle counts per instruction class
   localparam logic [1:0] LSBX_CYC_MEM = 2'h2;   // memory, stack and io bit ops
   localparam logic [1:0] LSBX_CYC_ALU = 2'h1;   // shifts, transfer flag, flag ops

   // status flag bit positions
   localparam int LSBX_FLAG_C = 0;
   localparam int LSBX_FLAG_Z = 1;
   localparam int LSBX_FLAG_N = 2;
   localparam int LSBX_FLAG_V = 3;
   localparam int LSBX_FLAG_S = 4;
   localparam int LSBX_FLAG_H = 5;
   localparam int LSBX_FLAG_T = 6;
   localparam int LSBX_FLAG_I = 7;

   // reset values
   localparam logic [7:0]  LSBX_FLAGS_RST = 8'h00;
   localparam logic [15:0] LSBX_SP_RST    = 16'h0000;

   // pointer pair select
   typedef enum logic [1:0] {
      LSBX_PTR_X,
      LSBX_PTR_Y,
      LSBX_PTR_Z
   } lsbx_ptr_e;

   // pointer adjust mode
   typedef enum logic [1:0] {
      LSBX_ADJ_NONE,
      LSBX_ADJ_POSTINC,
      LSBX_ADJ_PREDEC,
      LSBX_ADJ_DISP
   } lsbx_adj_e;

   // operation
   typedef enum logic [3:0] {
      LSBX_OP_LOAD_IND,
      LSBX_OP_STORE_IND,
      LSBX_OP_LOAD_DIRECT,
      LSBX_OP_STORE_DIRECT,
      LSBX_OP_PUSH,
      LSBX_OP_POP,
      LSBX_OP_IO_BIT_SET,
      LSBX_OP_IO_BIT_CLEAR,
      LSBX_OP_ROTATE_LEFT,
      LSBX_OP_ROTATE_RIGHT,
      LSBX_OP_SHIFT_LEFT,
      LSBX_OP_SHIFT_RIGHT,
      LSBX_OP_BIT_TO_T,
      LSBX_OP_T_TO_BIT,
      LSBX_OP_FLAG_SET,
      LSBX_OP_FLAG_CLEAR
   } lsbx_op_e;

   // decoded instruction
   typedef struct packed {
      lsbx_op_e   op;
      lsbx_ptr_e  ptr;
      lsbx_adj_e  adj;
      logic [4:0] reg_idx;   // destination or source register
      logic [5:0] disp;      // displacement q
      logic [15:0] addr;     // absolute address k, or io address
      logic [2:0] bit_sel;   // bit b or flag s
   } lsbx_instr_s;

   // data memory request
   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } lsbx_mem_s;

   // register file write
   typedef struct packed {
      logic       we;
      logic [4:0] idx;
      logic [7:0] data;
   } lsbx_rf_s;

endpackage : lsbx_pkg

// *** lsbx_exec.sv ***
// Purpose: executes load/store, stack, io bit, shift and flag instructions
// Assumes: register file and memories answer reads within the same cycle
// Notes:   one instruction accepted per idle cycle; busy shows a 2-cycle op
//
// What this block does
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displaced load reads pointer plus q
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - displaced store writes pointer plus q
// - direct load/store at absolute address, two cycles
// - push and pop on stack, two cycles
// - io bit set or clear, two cycles
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - single flag forced to one or zero
`timescale 1ns/1ps
module lsbx_exec
   import lsbx_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // instruction issue
   input  wire logic        instr_valid,
   input  wire lsbx_instr_s instr,
   output logic             ready,
   output logic             done,
   // register file read port and pointer pairs
   input  wire logic [7:0]  src_reg,
   input  wire logic [15:0] ptr_x,
   input  wire logic [15:0] ptr_y,
   input  wire logic [15:0] ptr_z,
   // data memory and io space
   output lsbx_mem_s        mem,
   output logic             io_req,
   output logic [5:0]       io_addr,
   output logic [7:0]       io_wdata,
   output logic             io_we,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic [7:0]  io_rdata,
   // register file write and pointer write back
   output lsbx_rf_s         rf_wr,
   output logic             ptr_we,
   output lsbx_ptr_e        ptr_sel,
   output logic [15:0]      ptr_wdata,
   // status flags and stack pointer
   output logic [7:0]       status_flags,
   output logic [15:0]      stack_ptr
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_ff;   // first stage
   logic rst_sync_ff;   // released reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   // wrap-around pointer arithmetic on the full pair
   function automatic logic [15:0] ptr_add(input logic [15:0] p, input logic [15:0] d);
      ptr_add = 16'(p + d);
   endfunction : ptr_add

   // zero, negative, overflow (n xor c) and sign from result and carry
   function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
                                               input logic c);
      logic [7:0] o;
      o = f;
      o[LSBX_FLAG_C] = c;
      o[LSBX_FLAG_Z] = (r == 8'h00);
      o[LSBX_FLAG_N] = r[7];
      o[LSBX_FLAG_V] = r[7] ^ c;
      o[LSBX_FLAG_S] = r[7] ^ (r[7] ^ c);
      shift_flags = o;
   endfunction : shift_flags

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef enum logic {LSBX_ST_IDLE, LSBX_ST_SECOND} lsbx_state_e;

   lsbx_state_e state_ff,     nxt_state;       // sequencer
   logic        ready_ff,     nxt_ready;       // idle, next instruction can be taken
   lsbx_instr_s held_ff,      nxt_held;        // instruction in flight
   logic [15:0] eff_ff,       nxt_eff;         // effective address
   logic [7:0]  flags_ff,     nxt_flags;       // status flags
   logic [15:0] sp_ff,        nxt_sp;          // stack pointer
   logic        done_ff,      nxt_done;        // completion pulse
   lsbx_mem_s   mem_ff,       nxt_mem;         // memory request
   logic        io_req_ff,    nxt_io_req;      // io request
   logic        io_we_ff,     nxt_io_we;       // io write
   logic [5:0]  io_addr_ff,   nxt_io_addr;     // io address
   logic [7:0]  io_wdata_ff,  nxt_io_wdata;    // io write data
   lsbx_rf_s    rf_ff,        nxt_rf;          // register write
   logic        ptr_we_ff,    nxt_ptr_we;      // pointer write back
   lsbx_ptr_e   ptr_sel_ff,   nxt_ptr_sel;     // pointer selected
   logic [15:0] ptr_wd_ff,    nxt_ptr_wd;      // pointer new value
   logic [15:0] ptr_val;                       // selected pointer value
   logic [7:0]  res;                           // shift result

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      nxt_state    = state_ff;
      nxt_held     = held_ff;
      nxt_eff      = eff_ff;
      nxt_flags    = flags_ff;
      nxt_sp       = sp_ff;
      nxt_done     = 1'b0;
      nxt_mem      = '0;
      nxt_io_req   = 1'b0;
      nxt_io_we    = 1'b0;
      nxt_io_addr  = io_addr_ff;
      nxt_io_wdata = io_wdata_ff;
      nxt_rf       = '0;
      nxt_ptr_we   = 1'b0;
      nxt_ptr_sel  = ptr_sel_ff;
      nxt_ptr_wd   = ptr_wd_ff;
      res          = 8'h00;
      // choose pointer pair
      unique case (instr.ptr)
         LSBX_PTR_X: ptr_val = ptr_x;
         LSBX_PTR_Y: ptr_val = ptr_y;
         default:    ptr_val = ptr_z;   // encoding 3 unused
      endcase
      unique case (state_ff)
         LSBX_ST_IDLE: begin
            if (instr_valid) begin
               nxt_held = instr;
               unique case (instr.op)
                  // first cycle of memory ops: form address, update pointer on post-increment or pre-decrement
                  LSBX_OP_LOAD_IND, LSBX_OP_STORE_IND: begin
                     nxt_state   = LSBX_ST_SECOND;
                     nxt_ptr_sel = instr.ptr;
                     unique case (instr.adj)
                        LSBX_ADJ_POSTINC: begin
                           nxt_eff    = ptr_val;
                           nxt_ptr_we = 1'b1;
                           nxt_ptr_wd = ptr_add(ptr_val, 16'h0001);
                        end
                        LSBX_ADJ_PREDEC: begin
                           nxt_eff    = ptr_add(ptr_val, 16'hffff);
                           nxt_ptr_we = 1'b1;
                           nxt_ptr_wd = ptr_add(ptr_val, 16'hffff);
                        end
                        LSBX_ADJ_DISP:
                           nxt_eff = ptr_add(ptr_val, {10'h000, instr.disp});
                        default:
                           nxt_eff = ptr_val;
                     endcase
                  end
                  LSBX_OP_LOAD_DIRECT, LSBX_OP_STORE_DIRECT: begin
                     nxt_state = LSBX_ST_SECOND;
                     nxt_eff   = instr.addr;
                  end
                  LSBX_OP_PUSH: begin
                     nxt_state = LSBX_ST_SECOND;
                     nxt_eff   = sp_ff;
                     nxt_sp    = ptr_add(sp_ff, 16'hffff);       // post-decrement on push
                  end
                  LSBX_OP_POP: begin
                     nxt_state = LSBX_ST_SECOND;
                     nxt_eff   = ptr_add(sp_ff, 16'h0001);
                     nxt_sp    = ptr_add(sp_ff, 16'h0001);       // pre-increment on pop
                  end
                  LSBX_OP_IO_BIT_SET, LSBX_OP_IO_BIT_CLEAR: begin
                     // first cycle registers the io read request; the read is answered in the second cycle
                     nxt_state   = LSBX_ST_SECOND;
                     nxt_io_req  = 1'b1;
                     nxt_io_addr = instr.addr[5:0];
                  end
                  LSBX_OP_ROTATE_LEFT: begin
                     res       = {src_reg[6:0], flags_ff[LSBX_FLAG_C]};
                     nxt_flags = shift_flags(flags_ff, res, src_reg[7]);
                     nxt_rf    = '{we: 1'b1, idx: instr.reg_idx, data: res};
                     nxt_done  = 1'b1;
                  end
                  LSBX_OP_ROTATE_RIGHT: begin
                     res       = {flags_ff[LSBX_FLAG_C], src_reg[7:1]};
                     nxt_flags = shift_flags(flags_ff, res, src_reg[0]);
                     nxt_rf    = '{we: 1'b1, idx: instr.reg_idx, data: res};
                     nxt_done  = 1'b1;
                  end
                  LSBX_OP_SHIFT_LEFT: begin
                     res       = {src_reg[6:0], 1'b0};
                     nxt_flags = shift_flags(flags_ff, res, src_reg[7]);
                     nxt_rf    = '{we: 1'b1, idx: instr.reg_idx, data: res};
                     nxt_done  = 1'b1;
                  end
                  LSBX_OP_SHIFT_RIGHT: begin
                     res       = {1'b0, src_reg[7:1]};
                     nxt_flags = shift_flags(flags_ff, res, src_reg[0]);
                     nxt_rf    = '{we: 1'b1, idx: instr.reg_idx, data: res};
                     nxt_done  = 1'b1;
                  end
                  LSBX_OP_BIT_TO_T: begin
                     nxt_flags[LSBX_FLAG_T] = src_reg[instr.bit_sel];
                     nxt_done = 1'b1;
                  end
                  LSBX_OP_T_TO_BIT: begin
                     res = src_reg;
                     res[instr.bit_sel] = flags_ff[LSBX_FLAG_T];
                     nxt_rf   = '{we: 1'b1, idx: instr.reg_idx, data: res};
                     nxt_done = 1'b1;
                  end
                  LSBX_OP_FLAG_SET: begin
                     nxt_flags[instr.bit_sel] = 1'b1;
                     nxt_done = 1'b1;
                  end
                  LSBX_OP_FLAG_CLEAR: begin
                     nxt_flags[instr.bit_sel] = 1'b0;
                     nxt_done = 1'b1;
                  end
               endcase
               // memory access issued from registered address in the next cycle
               if (instr.op inside {LSBX_OP_LOAD_IND, LSBX_OP_STORE_IND,
                                    LSBX_OP_LOAD_DIRECT, LSBX_OP_STORE_DIRECT,
                                    LSBX_OP_PUSH, LSBX_OP_POP}) begin
                  nxt_mem.req   = 1'b1;
                  nxt_mem.we    = instr.op inside {LSBX_OP_STORE_IND,
                                                   LSBX_OP_STORE_DIRECT, LSBX_OP_PUSH};
                  nxt_mem.addr  = nxt_eff;
                  nxt_mem.wdata = src_reg;
               end
            end
         end
         LSBX_ST_SECOND: begin
            // second cycle: capture read data or finish io modify
            nxt_state = LSBX_ST_IDLE;
            nxt_done  = 1'b1;
            unique case (held_ff.op)
               LSBX_OP_LOAD_IND, LSBX_OP_LOAD_DIRECT, LSBX_OP_POP:
                  nxt_rf = '{we: 1'b1, idx: held_ff.reg_idx, data: mem_rdata};
               LSBX_OP_IO_BIT_SET, LSBX_OP_IO_BIT_CLEAR: begin
                  nxt_io_req   = 1'b1;
                  nxt_io_we    = 1'b1;
                  nxt_io_wdata = io_rdata;
                  nxt_io_wdata[held_ff.bit_sel] =
                     (held_ff.op == LSBX_OP_IO_BIT_SET);
               end
               default: ;
            endcase
         end
      endcase
      // ready registered so the port comes straight from a flop
      nxt_ready = (nxt_state == LSBX_ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff    <= LSBX_ST_IDLE;
         ready_ff    <= 1'b1;
         held_ff     <= '0;
         eff_ff      <= 16'h0000;
         flags_ff    <= LSBX_FLAGS_RST;
         sp_ff       <= LSBX_SP_RST;
         done_ff     <= 1'b0;
         mem_ff      <= '0;
         io_req_ff   <= 1'b0;
         io_we_ff    <= 1'b0;
         io_addr_ff  <= 6'h00;
         io_wdata_ff <= 8'h00;
         rf_ff       <= '0;
         ptr_we_ff   <= 1'b0;
         ptr_sel_ff  <= LSBX_PTR_X;
         ptr_wd_ff   <= 16'h0000;
      end else begin
         state_ff    <= nxt_state;
         ready_ff    <= nxt_ready;
         held_ff     <= nxt_held;
         eff_ff      <= nxt_eff;
         flags_ff    <= nxt_flags;
         sp_ff       <= nxt_sp;
         done_ff     <= nxt_done;
         mem_ff      <= nxt_mem;
         io_req_ff   <= nxt_io_req;
         io_we_ff    <= nxt_io_we;
         io_addr_ff  <= nxt_io_addr;
         io_wdata_ff <= nxt_io_wdata;
         rf_ff       <= nxt_rf;
         ptr_we_ff   <= nxt_ptr_we;
         ptr_sel_ff  <= nxt_ptr_sel;
         ptr_wd_ff   <= nxt_ptr_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign ready        = ready_ff;
   assign done         = done_ff;
   assign mem          = mem_ff;
   assign io_req       = io_req_ff;
   assign io_we        = io_we_ff;
   assign io_addr      = io_addr_ff;
   assign io_wdata     = io_wdata_ff;
   assign rf_wr        = rf_ff;
   assign ptr_we       = ptr_we_ff;
   assign ptr_sel      = ptr_sel_ff;
   assign ptr_wdata    = ptr_wd_ff;
   assign status_flags = flags_ff;
   assign stack_ptr    = sp_ff;

endmodule : lsbx_exec

// *** lsbx_mem_model.sv ***
// Purpose: data memory and io space seen by lsbx_exec
// Assumes: reads answer in the request cycle
// Notes:   ram aliases on addr[7:0]; idle read lines show the inverse of the last value
`timescale 1ns/1ps
module lsbx_mem_model
   import lsbx_pkg::*;
(
   // clock
   input  wire logic       clk,
   // data memory
   input  wire lsbx_mem_s  mem,
   output logic [7:0]      mem_rdata,
   // io space
   input  wire logic       io_req,
   input  wire logic       io_we,
   input  wire logic [5:0] io_addr,
   input  wire logic [7:0] io_wdata,
   output logic [7:0]      io_rdata
);
   logic [7:0] ram [256];  // data bytes
   logic [7:0] io  [64];   // io registers
   logic [7:0] last_m;     // last memory read value
   logic [7:0] last_i;     // last io read value
   ////////////////////////////////////////////////////////////////////////////////
   // preload with a known pattern
   initial begin
      for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'ha5;
      for (int i = 0; i < 64; i++) io[i] = 8'(i) ^ 8'h3c;
      last_m = 8'h00;
      last_i = 8'h00;
   end
   // idle lines never hold the old value, so a late sample is caught
   assign mem_rdata = mem.req ? ram[mem.addr[7:0]] : ~last_m;
   assign io_rdata  = (io_req && !io_we) ? io[io_addr] : ~last_i;
   // writes land at the clock edge ending the request cycle
   always @(posedge clk) begin
      if (mem.req) last_m <= mem_rdata;
      if (mem.req && mem.we) ram[mem.addr[7:0]] <= mem.wdata;
      if (io_req && !io_we) last_i <= io_rdata;
      if (io_req && io_we) io[io_addr] <= io_wdata;
   end
endmodule : lsbx_mem_model

// *** lsbx_exec_sva.sv ***
// Purpose: port checker for lsbx_exec
// Assumes: one clock domain, rst_n active low
// Notes:   bound to every lsbx_exec instance
`timescale 1ns/1ps
module lsbx_exec_chk
   import lsbx_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // issue side
   input wire logic        instr_valid,
   input wire lsbx_instr_s instr,
   input wire logic        ready,
   input wire logic        done,
   input wire logic [7:0]  src_reg,
   input wire logic [15:0] ptr_x,
   input wire logic [15:0] ptr_y,
   input wire logic [15:0] ptr_z,
   // results
   input wire lsbx_mem_s   mem,
   input wire lsbx_rf_s    rf_wr,
   input wire logic        ptr_we,
   input wire logic [15:0] ptr_wdata,
   input wire logic [7:0]  status_flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic        take;  // instruction accepted
   logic        two;   // accepted op is a two-cycle op
   logic        ind;   // accepted indirect memory op
   logic [15:0] pv;    // selected pointer value
   logic [7:0]  fm;    // one-hot bit or flag mask
   assign take = instr_valid && ready;
   assign two  = take && (instr.op < LSBX_OP_ROTATE_LEFT);
   assign ind  = take && (instr.op inside {LSBX_OP_LOAD_IND, LSBX_OP_STORE_IND});
   assign pv   = (instr.ptr == LSBX_PTR_X) ? ptr_x : (instr.ptr == LSBX_PTR_Y) ? ptr_y : ptr_z;
   assign fm   = 8'h01 << instr.bit_sel;
   ////////////////////////////////////////////////////////////////////////////////
   // busy one cycle, then done with ready back
   sequence s_busy_done;
      !ready && !done ##1 ready && done;
   endsequence
   a_two_cycle_op: assert property (two |=> s_busy_done)
      else $error("two-cycle op timing wrong");
   a_one_cycle_op: assert property (take && !two |=> done && ready && !mem.req)
      else $error("one-cycle op timing wrong");
   a_postinc_ptr: assert property (ind && instr.adj == LSBX_ADJ_POSTINC |=> mem.req &&
      mem.addr == $past(pv) && ptr_we && ptr_wdata == $past(pv) + 16'h0001)
      else $error("post-increment address or pointer wrong");
   a_predec_ptr: assert property (ind && instr.adj == LSBX_ADJ_PREDEC |=> mem.req &&
      mem.addr == $past(pv) - 16'h0001 && ptr_we && ptr_wdata == mem.addr)
      else $error("pre-decrement address or pointer wrong");
   a_disp_addr: assert property (ind && instr.adj == LSBX_ADJ_DISP |=> mem.req &&
      mem.addr == $past(pv) + {10'h000, $past(instr.disp)} && !ptr_we)
      else $error("displaced address wrong or pointer touched");
   a_rotate_left: assert property (take && instr.op == LSBX_OP_ROTATE_LEFT |=> rf_wr.we &&
      rf_wr.data == {$past(src_reg[6:0]), $past(status_flags[0])} &&
      status_flags[0] == $past(src_reg[7]))
      else $error("rotate left result wrong");
   a_shift_zero: assert property (take && instr.op inside {LSBX_OP_SHIFT_LEFT,
      LSBX_OP_SHIFT_RIGHT} |=> rf_wr.data == (($past(instr.op) == LSBX_OP_SHIFT_LEFT) ?
      {$past(src_reg[6:0]), 1'b0} : {1'b0, $past(src_reg[7:1])}))
      else $error("logical shift result wrong");
   a_t_from_bit: assert property (take && instr.op == LSBX_OP_BIT_TO_T |=>
      status_flags == (($past(status_flags) & 8'hbf) | ({7'h00, $past(src_reg[instr.bit_sel])} << 6)))
      else $error("transfer flag copy wrong");
   a_flag_force: assert property (take && instr.op inside {LSBX_OP_FLAG_SET,
      LSBX_OP_FLAG_CLEAR} |=> status_flags == (($past(instr.op) == LSBX_OP_FLAG_SET) ?
      ($past(status_flags) | $past(fm)) : ($past(status_flags) & ~$past(fm))))
      else $error("single flag force wrong");
endmodule : lsbx_exec_chk
bind lsbx_exec lsbx_exec_chk chk (.clk, .rst_n, .instr_valid, .instr, .ready, .done, .src_reg,
   .ptr_x, .ptr_y, .ptr_z, .mem, .rf_wr, .ptr_we, .ptr_wdata, .status_flags);

// *** tb.sv ***
// Purpose: self-checking bench for lsbx_exec
// Assumes: memory model preloaded with i ^ a5, io with i ^ 3c
// Notes:   row field a carries address, displacement a[5:0] and bit select a[10:8]
`timescale 1ns/1ps
module tb;
   import lsbx_pkg::*;
   typedef struct {lsbx_op_e op; lsbx_ptr_e pt; lsbx_adj_e aj; logic [15:0] a; logic [7:0] s;
      logic [15:0] p; logic [8:0] rd; logic [16:0] ma; logic [7:0] f;} lsbx_row_s;
   logic        clk, rst_n, instr_valid, ready, done, io_req, io_we, ptr_we;
   lsbx_instr_s instr;                      // issued instruction
   logic [7:0]  src_reg, mem_rdata, io_rdata, io_wdata, status_flags, ef, m;
   logic [15:0] ptr_x, ptr_y, ptr_z, ptr_wdata, stack_ptr, sp_exp;
   logic [5:0]  io_addr;
   lsbx_mem_s   mem;                        // memory request
   lsbx_rf_s    rf_wr;                      // register write
   lsbx_ptr_e   ptr_sel;                    // pointer written back
   int          n_mismatch, checked, cyc;   // counters
   // rd 9'h100 and ma 17'h10000 mean no register write and no memory access
   lsbx_row_s rows [23] = '{
   '{LSBX_OP_LOAD_IND,LSBX_PTR_X,LSBX_ADJ_POSTINC,16'h0000,8'h00,16'hffff,9'h05a,17'h0ffff,8'h00},
   '{LSBX_OP_LOAD_IND,LSBX_PTR_Y,LSBX_ADJ_PREDEC,16'h0000,8'h00,16'h0000,9'h05a,17'h0ffff,8'h00},
   '{LSBX_OP_LOAD_IND,LSBX_PTR_Z,LSBX_ADJ_DISP,16'h003f,8'h00,16'h0100,9'h09a,17'h0013f,8'h00},
   '{LSBX_OP_STORE_IND,LSBX_PTR_Z,LSBX_ADJ_POSTINC,16'h0000,8'hc3,16'h0010,9'h100,17'h00010,8'h00},
   '{LSBX_OP_STORE_IND,LSBX_PTR_X,LSBX_ADJ_PREDEC,16'h0000,8'h3c,16'h0020,9'h100,17'h0001f,8'h00},
   '{LSBX_OP_STORE_IND,LSBX_PTR_Y,LSBX_ADJ_DISP,16'h0005,8'h77,16'h0030,9'h100,17'h00035,8'h00},
   '{LSBX_OP_LOAD_DIRECT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0010,8'h00,16'h0000,9'h0c3,17'h00010,8'h00},
   '{LSBX_OP_LOAD_DIRECT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h001f,8'h00,16'h0000,9'h03c,17'h0001f,8'h00},
   '{LSBX_OP_LOAD_DIRECT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0035,8'h00,16'h0000,9'h077,17'h00035,8'h00},
   '{LSBX_OP_STORE_DIRECT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0040,8'h11,16'h0000,9'h100,17'h00040,8'h00},
   '{LSBX_OP_LOAD_DIRECT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0040,8'h00,16'h0000,9'h011,17'h00040,8'h00},
   '{LSBX_OP_PUSH,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h99,16'h0000,9'h100,17'h00000,8'h00},
   '{LSBX_OP_POP,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h00,16'h0000,9'h099,17'h00000,8'h00},
   '{LSBX_OP_IO_BIT_SET,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0205,8'h00,16'h0000,9'h03d,17'h10000,8'h00},
   '{LSBX_OP_IO_BIT_CLEAR,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0005,8'h00,16'h0000,9'h03c,17'h10000,8'h00},
   '{LSBX_OP_ROTATE_LEFT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h80,16'h0000,9'h000,17'h10000,8'h1b},
   '{LSBX_OP_ROTATE_RIGHT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h01,16'h0000,9'h080,17'h10000,8'h15},
   '{LSBX_OP_SHIFT_LEFT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h80,16'h0000,9'h000,17'h10000,8'h1b},
   '{LSBX_OP_ROTATE_LEFT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h01,16'h0000,9'h003,17'h10000,8'h00},
   '{LSBX_OP_SHIFT_RIGHT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0000,8'h02,16'h0000,9'h001,17'h10000,8'h00},
   '{LSBX_OP_BIT_TO_T,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0500,8'h20,16'h0000,9'h100,17'h10000,8'h40},
   '{LSBX_OP_T_TO_BIT,LSBX_PTR_X,LSBX_ADJ_NONE,16'h0300,8'h00,16'h0000,9'h008,17'h10000,8'h40},
   '{LSBX_OP_LOAD_IND,LSBX_PTR_Y,LSBX_ADJ_NONE,16'h0000,8'h00,16'h0040,9'h011,17'h00040,8'h40}};
   ////////////////////////////////////////////////////////////////////////////////
   lsbx_exec DUT (.clk, .rst_n, .instr_valid, .instr, .ready, .done, .src_reg, .ptr_x, .ptr_y,
      .ptr_z, .mem, .io_req, .io_addr, .io_wdata, .io_we, .mem_rdata, .io_rdata, .rf_wr, .ptr_we,
      .ptr_sel, .ptr_wdata, .status_flags, .stack_ptr);
   lsbx_mem_model mdl (.clk, .mem, .mem_rdata, .io_req, .io_we, .io_addr, .io_wdata, .io_rdata);
   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // issue one row, watch the answer until done, bounded
   task automatic run(input lsbx_row_s r);
      logic [8:0]  rd;
      logic [16:0] ma;
      int          n;
      logic [16:0] pw, pe;   // pointer write back seen and expected
      lsbx_ptr_e   ps;       // pointer pair written back
      rd = 9'h100;
      ma = 17'h10000;
      n = 0;
      pw = 17'h00000;
      pe = 17'h00000;
      ps = LSBX_PTR_X;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= '{r.op, r.pt, r.aj, 5'h03, r.a[5:0], r.a, r.a[10:8]};
      src_reg <= r.s;
      ptr_x <= r.p;
      ptr_y <= r.p;
      ptr_z <= r.p;
      @(posedge clk);
      instr_valid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
         if (rf_wr.we === 1'b1) rd = {1'b0, rf_wr.data};
         if (io_req === 1'b1 && io_we === 1'b1) rd = {1'b0, io_wdata};
         if (mem.req === 1'b1) ma = {1'b0, mem.addr};
         if (ptr_we === 1'b1) pw = {1'b1, ptr_wdata};
         if (ptr_we === 1'b1) ps = ptr_sel;
      end while (done !== 1'b1 && n < 4);
      check("cycles", 17'(n), 17'((r.op < LSBX_OP_ROTATE_LEFT) ? LSBX_CYC_MEM : LSBX_CYC_ALU));
      check("result", 17'(rd), 17'(r.rd));
      check("mem_addr", ma, r.ma);
      check("flags", 17'(status_flags), 17'(r.f));
      // pointer and stack expectations follow the adjust rules
      if (r.op inside {LSBX_OP_LOAD_IND, LSBX_OP_STORE_IND} && r.aj == LSBX_ADJ_POSTINC)
         pe = {1'b1, 16'(r.p + 16'h0001)};
      if (r.op inside {LSBX_OP_LOAD_IND, LSBX_OP_STORE_IND} && r.aj == LSBX_ADJ_PREDEC)
         pe = {1'b1, 16'(r.p - 16'h0001)};
      if (r.op == LSBX_OP_PUSH) sp_exp = 16'(sp_exp - 16'h0001);
      if (r.op == LSBX_OP_POP) sp_exp = 16'(sp_exp + 16'h0001);
      check("ptr_wb", pw, pe);
      if (pe[16]) check("ptr_sel", 17'(ps), 17'(r.pt));
      check("stack_ptr", 17'(stack_ptr), 17'(sp_exp));
   endtask : run
   // print counts and verdict, then stop
   task automatic conclude();
      $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         n_mismatch++;
         conclude();
      end
   end
   // main sequence
   initial begin
      {rst_n, instr_valid, src_reg, ptr_x, ptr_y, ptr_z} = '0;
      instr = '0;
      sp_exp = LSBX_SP_RST;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("ready", 17'(ready), 17'h00001);
      check("rst_flags", 17'(status_flags), 17'(LSBX_FLAGS_RST));
      check("rst_sp", 17'(stack_ptr), 17'(LSBX_SP_RST));
      $display("test reset done");
      foreach (rows[i]) run(rows[i]);
      $display("test table done");
      // every flag forced up and down in turn
      ef = 8'h40;
      for (int s = 0; s < 8; s++) begin
         m = 8'h01 << s;
         run('{LSBX_OP_FLAG_SET, LSBX_PTR_X, LSBX_ADJ_NONE, {5'h00, 3'(s), 8'h00}, 8'h00,
            16'h0000, 9'h100, 17'h10000, ef | m});
         ef = ef & ~m;
         run('{LSBX_OP_FLAG_CLEAR, LSBX_PTR_X, LSBX_ADJ_NONE, {5'h00, 3'(s), 8'h00}, 8'h00,
            16'h0000, 9'h100, 17'h10000, ef});
      end
      $display("test flags done");
      conclude();
   end
endmodule : tb
